// file: src/adc_link_pkg.sv
package adc_link_pkg;
	// result width, falling clock edge indices, full scale codes and synchronizer settings
	localparam int unsigned RESULT_BITS      = 16;
	localparam int unsigned EDGE_CNT_W       = 5;
	localparam logic [4:0]  EDGE_ZERO_BIT    = 5'h02;
	localparam logic [4:0]  EDGE_MSB         = 5'h03;
	localparam logic [4:0]  EDGE_ACQ         = 5'h12;
	localparam logic [4:0]  EDGE_MAX         = 5'h1F;
	localparam int unsigned ACQ_TRACK_PERIODS = 3;
	localparam logic [15:0] CODE_POS_FULL    = 16'h7FFF;
	localparam logic [15:0] CODE_NEG_FULL    = 16'h8000;
	localparam int unsigned SYNC_STAGES      = 2;
	localparam logic        SYNC_RESET_VAL   = 1'b1;
endpackage

// file: src/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
	parameter int unsigned WIDTH = 2
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// pins
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = pin_i;
		sync_d = meta_q;
	end

	// idle-high reset so no edge is seen at release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= {WIDTH{adc_link_pkg::SYNC_RESET_VAL}};
			sync_q <= {WIDTH{adc_link_pkg::SYNC_RESET_VAL}};
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule // pin_sync

// file: src/adc_serial_out.sv
`timescale 1ns/100ps
// Overview of operation
// RULE_01: frame runs from select low to high
// RULE_02: output released when idle and first period
// RULE_03: select fall samples input, one conversion
// RULE_04: convert 17 periods, acquire at 18th fall
// RULE_05: track input three periods, low power
// RULE_06: select falls clock high: first clock fall
// RULE_07: select falls clock low: counts as fall
// RULE_08: simultaneous falls enter conversion
// RULE_09: host never drops select on rising clock
// RULE_10: select high always means acquisition
// RULE_11: host waits acquisition time before next frame
// RULE_12: host may idle clock after last bit
// RULE_13: result is 16-bit two's complement
// RULE_14: zero at 2nd fall, MSB from 3rd
// RULE_15: host captures bits on rising edges
// RULE_16: select rise releases output, aborts conversion
// RULE_17: full scale codes 7FFF and 8000
// RULE_18: host clock twenty times sample rate
// RULE_19: edge count cleared while select high
module adc_serial_out (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// link pins
	input  wire logic        frame_n_i,
	input  wire logic        sclk_i,
	output logic             dout_o,
	output logic             dout_oe_n_o,
	// analog side, already digitised two's complement code
	input  wire logic [15:0] sample_code_i,
	// phase status
	output logic             conversion_phase_o,
	output logic             acquisition_phase_o,
	output logic             tracking_o,
	output logic             sample_strobe_o
);
	logic [1:0] pins_s;
	logic       frame_n_s;
	logic       sclk_s;
	logic       frame_n_prev_q;
	logic       sclk_prev_q;
	logic       frame_fall;
	logic       sclk_fall;
	logic       frame_active;

	typedef enum {ST_IDLE, ST_WAIT_FALL, ST_CONV, ST_ACQ} phase_t;
	phase_t           state_q,   state_d;
	logic [4:0]       edge_q,    edge_d;
	logic [15:0]      shift_q,   shift_d;
	logic [1:0]       track_q,   track_d;
	logic             dout_q,    dout_d;
	logic             oe_n_q,    oe_n_d;
	logic             strobe_q,  strobe_d;

	pin_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pin_i ({frame_n_i, sclk_i}),
		.sync_o(pins_s)
	);

	assign frame_n_s    = pins_s[1];
	assign sclk_s       = pins_s[0];
	assign frame_fall   = frame_n_prev_q && !frame_n_s; // RULE_01
	assign sclk_fall    = sclk_prev_q && !sclk_s;
	assign frame_active = !frame_n_s;

	function automatic logic [4:0] inc_sat(input logic [4:0] v);
		inc_sat = (v == adc_link_pkg::EDGE_MAX) ? v : v + 5'h01;
	endfunction

	always_comb begin
		state_d  = state_q;
		edge_d   = edge_q;
		shift_d  = shift_q;
		track_d  = track_q;
		dout_d   = dout_q;
		oe_n_d   = oe_n_q;
		strobe_d = 1'b0;
		if (!frame_active) begin
			// abort and release, count cleared
			state_d = ST_IDLE; // RULE_10 RULE_16
			edge_d  = 5'h00; // RULE_19
			oe_n_d  = 1'b1; // RULE_02 RULE_16
			dout_d  = 1'b0;
			// tracking keeps counting clock falls after release
			if (sclk_fall && track_q != 2'h0)
				track_d = track_q - 2'h1; // RULE_05
		end else if (frame_fall) begin
			// one sample per select fall
			shift_d  = sample_code_i; // RULE_03 RULE_13 RULE_17
			strobe_d = 1'b1;
			track_d  = 2'h0;
			oe_n_d   = 1'b1; // RULE_02
			if (!sclk_s || sclk_fall) begin
				// select fall stands in for first clock fall
				state_d = ST_CONV; // RULE_07 RULE_08
				edge_d  = 5'h01;
			end else begin
				state_d = ST_WAIT_FALL; // RULE_06
				edge_d  = 5'h00;
			end
		end else if (sclk_fall) begin
			case (state_q)
				ST_WAIT_FALL: begin
					state_d = ST_CONV; // RULE_06
					edge_d  = 5'h01;
				end
				ST_CONV, ST_ACQ: begin
					edge_d = inc_sat(edge_q); // RULE_19
					if (edge_d == adc_link_pkg::EDGE_ZERO_BIT) begin
						oe_n_d = 1'b0; // RULE_02 RULE_14
						dout_d = 1'b0;
					end else if (edge_d >= adc_link_pkg::EDGE_MSB &&
						edge_d <= adc_link_pkg::EDGE_ACQ) begin
						dout_d  = shift_q[15]; // RULE_14
						shift_d = {shift_q[14:0], 1'b0};
					end
					if (edge_d == adc_link_pkg::EDGE_ACQ) begin
						state_d = ST_ACQ; // RULE_04
						track_d = 2'(adc_link_pkg::ACQ_TRACK_PERIODS); // RULE_05
					end else if (state_q == ST_ACQ && track_q != 2'h0) begin
						track_d = track_q - 2'h1; // RULE_05
					end
				end
				default: state_d = state_q;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q        <= ST_IDLE;
			edge_q         <= 5'h00;
			shift_q        <= 16'h0000;
			track_q        <= 2'h0;
			dout_q         <= 1'b0;
			oe_n_q         <= 1'b1;
			strobe_q       <= 1'b0;
			frame_n_prev_q <= 1'b1;
			sclk_prev_q    <= 1'b1;
		end else begin
			state_q        <= state_d;
			edge_q         <= edge_d;
			shift_q        <= shift_d;
			track_q        <= track_d;
			dout_q         <= dout_d;
			oe_n_q         <= oe_n_d;
			strobe_q       <= strobe_d;
			frame_n_prev_q <= frame_n_s;
			sclk_prev_q    <= sclk_s;
		end
	end

	logic conv_q;
	logic conv_d;
	logic acq_q;
	logic acq_d;
	logic trk_q;
	logic trk_d;

	always_comb begin
		conv_d = (state_d == ST_CONV); // RULE_04
		acq_d  = (state_d != ST_CONV); // RULE_10
		trk_d  = (track_d != 2'h0); // RULE_05
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_q <= 1'b0;
			acq_q  <= 1'b1;
			trk_q  <= 1'b0;
		end else begin
			conv_q <= conv_d;
			acq_q  <= acq_d;
			trk_q  <= trk_d;
		end
	end

	assign dout_o              = dout_q;
	assign dout_oe_n_o         = oe_n_q;
	assign sample_strobe_o     = strobe_q;
	assign conversion_phase_o  = conv_q;
	assign acquisition_phase_o = acq_q;
	assign tracking_o          = trk_q;

	property p_release_idle;
		@(posedge clk_i) disable iff (rst_i)
		frame_n_s |=> dout_oe_n_o;
	endproperty
	a_release_idle: assert property (p_release_idle) else $error("output driven while idle"); // RULE_02

	property p_idle_acq;
		@(posedge clk_i) disable iff (rst_i)
		frame_n_s |=> acquisition_phase_o && !conversion_phase_o;
	endproperty
	a_idle_acq: assert property (p_idle_acq) else $error("not acquiring while idle"); // RULE_10

	property p_one_sample;
		@(posedge clk_i) disable iff (rst_i)
		sample_strobe_o |=> !sample_strobe_o;
	endproperty
	a_one_sample: assert property (p_one_sample) else $error("double sample strobe"); // RULE_03

	property p_strobe_cause;
		@(posedge clk_i) disable iff (rst_i)
		sample_strobe_o |-> $past(frame_fall);
	endproperty
	a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without select fall"); // RULE_01

	property p_fall_low_conv;
		@(posedge clk_i) disable iff (rst_i)
		frame_fall && !sclk_s |=> conversion_phase_o && edge_q == 5'h01;
	endproperty
	a_fall_low_conv: assert property (p_fall_low_conv) else $error("no conversion on low clock"); // RULE_07

	property p_fall_high_wait;
		@(posedge clk_i) disable iff (rst_i)
		frame_fall && sclk_s && !sclk_fall |=> !conversion_phase_o;
	endproperty
	a_fall_high_wait: assert property (p_fall_high_wait) else $error("converted before clock fall"); // RULE_06

	property p_acq_at_18;
		@(posedge clk_i) disable iff (rst_i)
		frame_active && edge_q == adc_link_pkg::EDGE_ACQ |-> state_q == ST_ACQ;
	endproperty
	a_acq_at_18: assert property (p_acq_at_18) else $error("not acquiring after 18th fall"); // RULE_04

	property p_enable_at_2;
		@(posedge clk_i) disable iff (rst_i)
		!dout_oe_n_o && frame_active |-> edge_q >= adc_link_pkg::EDGE_ZERO_BIT;
	endproperty
	a_enable_at_2: assert property (p_enable_at_2) else $error("driven before 2nd fall"); // RULE_14

	property p_count_clear;
		@(posedge clk_i) disable iff (rst_i)
		frame_n_s |=> edge_q == 5'h00;
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("edge count not cleared"); // RULE_19
endmodule // adc_serial_out

// file: dv/host_model.sv
`timescale 1ns/100ps
module host_model (
	// clock
	input  wire logic        clk_i,
	// link pins
	input  wire logic        dout_i,
	input  wire logic        dout_oe_n_i,
	output logic             frame_n_o,
	output logic             sclk_o,
	// captured result
	output logic [16:0]      word_o,
	output logic             first_oe_n_o,
	output logic             done_o
);
	logic last_q;
	// released line shows the inverse of the last bit, never a stale copy
	wire line = dout_oe_n_i ? ~last_q : dout_i;
	always @(posedge clk_i) if (!dout_oe_n_i) last_q <= dout_i;
	initial begin
		frame_n_o = 1;
		sclk_o = 1;
		word_o = 0;
		first_oe_n_o = 0;
		done_o = 0;
		last_q = 0;
	end
	task automatic half();
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	// mode 0: select falls with clock high, 1: clock low, 2: both together
	task automatic frame(input int mode, input int falls);
		word_o = 0;
		if (mode == 1) begin
			sclk_o = 0;
			half();
		end
		frame_n_o = 0;
		if (mode == 2) sclk_o = 0;
		half();
		for (int k = 1; k <= falls; k++) begin
			if (k > 1 || mode == 0) begin
				sclk_o = 0;
				half();
			end
			sclk_o = 1;
			if (k == 1) first_oe_n_o = dout_oe_n_i;
			else word_o = {word_o[15:0], line};
			half();
		end
		frame_n_o = 1;
		repeat (3) half();
		done_o = 1;
		@(posedge clk_i);
		#1 done_o = 0;
	endtask
endmodule // host_model

// file: dv/adc_serial_out_tb.sv
`timescale 1ns/100ps
module adc_serial_out_tb;
	logic        clk_i, rst_i, frame_n, sclk, dout, oe_n, conv, acq, trk, strobe, oe1, done;
	logic [15:0] code;
	logic [16:0] word;
	logic [16:0] exp_q[$];
	int          miscompares = 0, compares = 0, seed = 72582, strobes = 0, convs = 0;
	adc_serial_out DUT (.clk_i(clk_i), .rst_i(rst_i), .frame_n_i(frame_n), .sclk_i(sclk),
		.dout_o(dout), .dout_oe_n_o(oe_n), .sample_code_i(code),
		.conversion_phase_o(conv), .acquisition_phase_o(acq), .tracking_o(trk),
		.sample_strobe_o(strobe));
	host_model HOST (.clk_i(clk_i), .dout_i(dout), .dout_oe_n_i(oe_n), .frame_n_o(frame_n),
		.sclk_o(sclk), .word_o(word), .first_oe_n_o(oe1), .done_o(done));
	initial begin
		clk_i = 0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic chk(input string name, input logic [16:0] e, input logic [16:0] s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", name, e, s);
		end
	endtask
	always @(posedge done) chk("word", exp_q.pop_front(), word);
	always @(posedge clk_i) if (strobe === 1'b1) strobes++;
	always @(posedge clk_i) if (conv === 1'b1) convs++;
	task automatic run(input int mode, input int falls, input logic [15:0] c);
		@(posedge clk_i);
		#1 code = c;
		exp_q.push_back({1'b0, c} >> (18 - falls));
		strobes = 0;
		convs = 0;
		HOST.frame(mode, falls);
		chk("oe_first", 1, oe1);
		chk("strobes", 1, strobes);
		chk("oe_after", 1, oe_n);
		chk("conv", 0, conv);
		// 17 link periods of 8 clocks each, or cut short by the select rise
		chk("conv_len", (falls == 18) ? 17 * 8 : falls * 8, convs);
		chk("acq", 1, acq);
		if (falls == 18) chk("track", 1, trk);
		$display("frame mode %0d falls %0d done", mode, falls);
	endtask
	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#2000000;
		miscompares++;
		report_and_stop();
	end
	initial begin
		rst_i = 1;
		code = 0;
		repeat (8) @(posedge clk_i);
		#1 rst_i = 0;
		repeat (4) @(posedge clk_i);
		chk("acq_idle", 1, acq);
		for (int m = 0; m < 3; m++) run(m, 18, m[0] ? 16'h7FFF : 16'h8000);
		repeat (6) run($unsigned($random(seed)) % 3, 18, 16'($random(seed)));
		for (int n = 3; n < 18; n += 7) run(n % 3, n, 16'($random(seed)));
		run(1, 18, 16'($random(seed)));
		report_and_stop();
	end
endmodule // adc_serial_out_tb
